// File: core/acp_bank_if.sv
// Signals between the serial engine and the register bank.
// Toggles and words leave the serial clock domain; the bank synchronises.
`timescale 1ns/1ps
`default_nettype none
interface acp_bank_if;
   logic wr_tgl;
   logic [2:0] wr_sel;
   logic [23:0] wr_word;
   logic rd_tgl;
   logic prst_tgl;
   logic [2:0] rd_sel;
   logic [23:0] rd_word;
   logic ready;

   modport port (
      output wr_tgl, wr_sel, wr_word, rd_tgl, prst_tgl, rd_sel,
      input rd_word, ready
   );
   modport bank (
      input wr_tgl, wr_sel, wr_word, rd_tgl, prst_tgl, rd_sel,
      output rd_word, ready
   );
endinterface
`default_nettype wire

// File: core/acp_command_port.sv
// Serial command and readout port of a measurement converter.
// Assumes a host drives sclk_in, cs_n_in and din_in; converter core on clk_in.
// Function
// - Output pin carries the output shift register, loaded from the selected register.
// - Finished conversion pulls the output pin low as a ready signal.
// - Unread result: pin returns high before the next update.
// - Output bits change on falling serial clock edges; host samples on rising.
// - Each end of conversion clears the not-ready bit (bit 7) of the status register.
// - Chip select high floats the pin; ready flag still updates.
// - Input bits shift in and go to the register the command selected; writes to data and identity are dropped.
// - Command register is eight bits, write-only.
// - Command byte decides read or write and the target register.
// - After the following transfer completes, the port waits for a command.
// - After reset the port waits for a command byte.
// - 32 consecutive ones on the input reset the whole part.
// - Command bits arrive most significant first.
// - Command layout: gate, direction, select, continuous readout, two zeros; reset zero.
// - Gate bit must be 0; ones keep the port at the first bit.
// - Direction bit: 0 writes, 1 reads the addressed register.
// - Stream command enters continuous readout; exit command while ready leaves it.
// - Select codes: command/status, mode, config, data, identity, IO, offset, full-scale.
`timescale 1ns/1ps
`default_nettype none
module acp_command_port (
   input wire logic clk_in,           // System clock, 100 MHz.
   input wire logic rst_n_in,         // Asynchronous reset, active low.
   input wire logic ce_in,            // Clock enable, freezes all state but the serial-side synchronisers.
   input wire logic sclk_in,          // Serial clock from the host.
   input wire logic cs_n_in,          // Chip select, active low.
   input wire logic din_in,           // Serial data from the host.
   output logic dout_out,             // Serial data or ready level.
   output logic dout_oe_out,          // Output pin drive enable.
   input wire logic conv_done_in,     // Conversion finished pulse.
   input wire logic [23:0] conv_data_in, // Finished conversion result.
   input wire logic update_near_in,   // Next update imminent pulse.
   output logic [15:0] mode_out,      // Mode register.
   output logic [15:0] config_out,    // Configuration register.
   output logic [7:0] io_out,         // IO register.
   output logic [23:0] offset_out,    // Offset register.
   output logic [23:0] fullscale_out, // Full-scale register.
   output logic part_reset_out        // Whole-part reset pulse.
);
   acp_bank_if bank ();

   acp_pkg::acp_state_t state_reg;
   logic [4:0] bit_cnt_reg;
   logic [6:0] cmd_sh_reg;
   logic [7:0] command_byte_reg;
   logic [2:0] register_select_field;
   logic [23:0] rx_sh_reg;
   logic [23:0] wr_word_reg;
   logic [23:0] tx_sh_reg;
   logic [5:0] ones_cnt_reg;
   logic wr_tgl_reg;
   logic rd_tgl_reg;
   logic prst_tgl_reg;
   logic ce_s1_reg;
   logic ce_s_reg;
   logic rdy_s1_reg;
   logic rdy_s_reg;
   logic go;
   logic ones_hit;
   logic tx_active;
   logic [7:0] new_cmd;
   logic [23:0] rx_word;
   logic [2:0] new_sel;
   logic continuous_readout_bit;

   // Chip select and data are framed by the serial clock itself, so they
   // are sampled directly on its edges; only system signals are synchronised.
   assign go = ce_s_reg && !cs_n_in;
   assign new_cmd = {cmd_sh_reg, din_in};
   assign new_sel = new_cmd[acp_pkg::CMD_SEL_HI:acp_pkg::CMD_SEL_LO];
   assign continuous_readout_bit = new_cmd[acp_pkg::CONTINUOUS_READOUT_BIT];
   assign rx_word = {rx_sh_reg[22:0], din_in};
   assign ones_hit = go && din_in
      && ones_cnt_reg == acp_pkg::ONES_RESET_COUNT - 6'h01;
   assign tx_active = state_reg == acp_pkg::ST_RD
      || state_reg == acp_pkg::ST_STREAM;

   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ce_s1_reg <= 1'b0;
         ce_s_reg <= 1'b0;
         rdy_s1_reg <= 1'b0;
         rdy_s_reg <= 1'b0;
      end else begin
         ce_s1_reg <= ce_in;
         ce_s_reg <= ce_s1_reg;
         rdy_s1_reg <= bank.ready;
         rdy_s_reg <= rdy_s1_reg;
      end
   end

   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ones_cnt_reg <= 6'h00;
      end else if (go) begin
         if (din_in && !ones_hit) begin
            ones_cnt_reg <= ones_cnt_reg + 6'h01;
         end else begin
            ones_cnt_reg <= 6'h00;
         end
      end
   end

   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= acp_pkg::ST_CMD;
         bit_cnt_reg <= 5'h00;
         cmd_sh_reg <= 7'h00;
         command_byte_reg <= acp_pkg::CMD_RESET;
         register_select_field <= acp_pkg::SEL_COMM;
         rx_sh_reg <= 24'h000000;
         wr_word_reg <= 24'h000000;
         wr_tgl_reg <= 1'b0;
         rd_tgl_reg <= 1'b0;
         prst_tgl_reg <= 1'b0;
      end else if (go) begin
         if (ones_hit) begin
            state_reg <= acp_pkg::ST_CMD;
            bit_cnt_reg <= 5'h00;
            command_byte_reg <= acp_pkg::CMD_RESET;
            register_select_field <= acp_pkg::SEL_COMM;
            prst_tgl_reg <= !prst_tgl_reg;
         end else begin
            case (state_reg)
               acp_pkg::ST_CMD: begin
                  if (bit_cnt_reg != 5'h00 || !din_in) begin
                     if (bit_cnt_reg != acp_pkg::CMD_LAST_BIT) begin
                        cmd_sh_reg <= new_cmd[6:0];
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     end else begin
                        command_byte_reg <= new_cmd;
                        register_select_field <= new_sel;
                        bit_cnt_reg <= acp_pkg::reg_width(new_sel);
                        if (new_cmd[acp_pkg::CMD_DIR_BIT]) begin
                           if (new_sel == acp_pkg::SEL_DATA
                              && continuous_readout_bit) begin
                              state_reg <= acp_pkg::ST_STREAM;
                              cmd_sh_reg <= 7'h7f;
                           end else begin
                              state_reg <= acp_pkg::ST_RD;
                           end
                        end else if (new_sel != acp_pkg::SEL_COMM) begin
                           state_reg <= acp_pkg::ST_WR;
                        end else begin
                           bit_cnt_reg <= 5'h00;
                        end
                     end
                  end
               end
               acp_pkg::ST_WR: begin
                  rx_sh_reg <= rx_word;
                  bit_cnt_reg <= bit_cnt_reg - 5'h01;
                  if (bit_cnt_reg == 5'h01) begin
                     wr_word_reg <= rx_word;
                     wr_tgl_reg <= !wr_tgl_reg;
                     state_reg <= acp_pkg::ST_CMD;
                     bit_cnt_reg <= 5'h00;
                  end
               end
               acp_pkg::ST_RD: begin
                  bit_cnt_reg <= bit_cnt_reg - 5'h01;
                  if (bit_cnt_reg == 5'h01) begin
                     state_reg <= acp_pkg::ST_CMD;
                     bit_cnt_reg <= 5'h00;
                     if (register_select_field == acp_pkg::SEL_DATA) begin
                        rd_tgl_reg <= !rd_tgl_reg;
                     end
                  end
               end
               acp_pkg::ST_STREAM: begin
                  // The input is watched for the exit command while data streams.
                  cmd_sh_reg <= new_cmd[6:0];
                  if (new_cmd == acp_pkg::CMD_STREAM_EXIT && rdy_s_reg) begin
                     state_reg <= acp_pkg::ST_CMD;
                     bit_cnt_reg <= 5'h00;
                     command_byte_reg <= new_cmd;
                  end else if (bit_cnt_reg == 5'h01) begin
                     bit_cnt_reg <= acp_pkg::reg_width(acp_pkg::SEL_DATA);
                     rd_tgl_reg <= !rd_tgl_reg;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg - 5'h01;
                  end
               end
               default: begin
                  state_reg <= acp_pkg::ST_CMD;
                  bit_cnt_reg <= 5'h00;
               end
            endcase
         end
      end
   end

   // The selected register is loaded on the first falling edge of a word and
   // shifted on each later one. Bank words are steady while the host reads,
   // except the data and status words, which a conversion may change mid-read.
   always_ff @(negedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_sh_reg <= 24'h000000;
      end else if (go) begin
         if (tx_active
            && bit_cnt_reg == acp_pkg::reg_width(register_select_field)) begin
            tx_sh_reg <= bank.rd_word << (acp_pkg::WORD_W
               - acp_pkg::reg_width(register_select_field));
         end else begin
            tx_sh_reg <= {tx_sh_reg[22:0], 1'b0};
         end
      end
   end

   // Outside a readout the pin shows the ready level, low when ready.
   assign dout_out = tx_active ? tx_sh_reg[23] : !bank.ready;
   assign dout_oe_out = !cs_n_in;

   assign bank.wr_tgl = wr_tgl_reg;
   assign bank.wr_sel = register_select_field;
   assign bank.wr_word = wr_word_reg;
   assign bank.rd_tgl = rd_tgl_reg;
   assign bank.prst_tgl = prst_tgl_reg;
   assign bank.rd_sel = register_select_field;

   acp_reg_bank u_bank (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .lk(bank.bank),
      .conv_done_in(conv_done_in),
      .conv_data_in(conv_data_in),
      .update_near_in(update_near_in),
      .mode_out(mode_out),
      .config_out(config_out),
      .io_out(io_out),
      .offset_out(offset_out),
      .fullscale_out(fullscale_out),
      .part_reset_out(part_reset_out)
   );

   gate_hold_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      go && !ones_hit && state_reg == acp_pkg::ST_CMD
      && bit_cnt_reg == 5'h00 && din_in
      |=> state_reg == acp_pkg::ST_CMD && bit_cnt_reg == 5'h00)
      else $error("port left the first bit on a high gate bit");
   idle_return_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      go && state_reg == acp_pkg::ST_RD && bit_cnt_reg == 5'h01
      |=> state_reg == acp_pkg::ST_CMD && bit_cnt_reg == 5'h00)
      else $error("port did not return to await a command");
   select_freeze_a: assert property (@(posedge sclk_in)
      disable iff (!rst_n_in)
      cs_n_in |=> $stable(bit_cnt_reg) && $stable(state_reg))
      else $error("port moved while chip select was high");
   ones_reset_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      ones_hit |=> state_reg == acp_pkg::ST_CMD && bit_cnt_reg == 5'h00
      && prst_tgl_reg != $past(prst_tgl_reg))
      else $error("32 ones did not reset the part");
   read_dir_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      go && !ones_hit && state_reg == acp_pkg::ST_CMD
      && bit_cnt_reg == acp_pkg::CMD_LAST_BIT && new_cmd[6]
      |=> tx_active
      && bit_cnt_reg == acp_pkg::reg_width(register_select_field))
      else $error("read command did not start a readout");
   write_dir_a: assert property (@(posedge sclk_in) disable iff (!rst_n_in)
      go && !ones_hit && state_reg == acp_pkg::ST_CMD
      && bit_cnt_reg == acp_pkg::CMD_LAST_BIT && !new_cmd[6]
      && new_sel != acp_pkg::SEL_COMM
      |=> state_reg == acp_pkg::ST_WR
      && command_byte_reg == $past(new_cmd)
      && register_select_field == $past(new_sel))
      else $error("write command did not select its register");
   stream_enter_a: assert property (@(posedge sclk_in)
      disable iff (!rst_n_in)
      go && !ones_hit && state_reg == acp_pkg::ST_CMD
      && bit_cnt_reg == acp_pkg::CMD_LAST_BIT
      && new_cmd == acp_pkg::CMD_STREAM_ENTER
      |=> state_reg == acp_pkg::ST_STREAM)
      else $error("stream command did not enter continuous readout");
   shift_out_a: assert property (@(negedge sclk_in) disable iff (!rst_n_in)
      go && state_reg == acp_pkg::ST_RD && bit_cnt_reg != 5'h00
      && bit_cnt_reg < acp_pkg::reg_width(register_select_field)
      |=> !go || tx_sh_reg[23] == $past(tx_sh_reg[22]))
      else $error("output bit did not advance on the falling edge");
endmodule
`default_nettype wire

// File: core/acp_pkg.sv
// Constants, state codes and a helper function for the serial command port.
// Assumes nothing of its surroundings; used by the command port, the register bank and the bench.
package acp_pkg;

   // Register select codes carried in the command byte.
   localparam logic [2:0] SEL_COMM = 3'h0;
   localparam logic [2:0] SEL_MODE = 3'h1;
   localparam logic [2:0] SEL_CONF = 3'h2;
   localparam logic [2:0] SEL_DATA = 3'h3;
   localparam logic [2:0] SEL_ID = 3'h4;
   localparam logic [2:0] SEL_IO = 3'h5;
   localparam logic [2:0] SEL_OFFS = 3'h6;
   localparam logic [2:0] SEL_FSCL = 3'h7;

   // Command byte field positions.
   localparam int CMD_WEN_BIT = 7;
   localparam int CMD_DIR_BIT = 6;
   localparam int CMD_SEL_HI = 5;
   localparam int CMD_SEL_LO = 3;
   localparam int CONTINUOUS_READOUT_BIT = 2;

   // Command values and counts.
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] CMD_STREAM_ENTER = 8'h5c;
   localparam logic [7:0] CMD_STREAM_EXIT = 8'h58;
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;
   localparam logic [5:0] ONES_RESET_COUNT = 6'h20;
   localparam logic [4:0] WORD_W = 5'h18;

   // Register reset values.
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] CONF_RESET = 16'h0000;
   localparam logic [7:0] IO_RESET = 8'h00;
   localparam logic [23:0] OFFS_RESET = 24'h000000;
   localparam logic [23:0] FSCL_RESET = 24'h000000;
   localparam logic [23:0] DATA_RESET = 24'h000000;
   // Identity value is arbitrary.
   localparam logic [7:0] ID_DEFAULT = 8'h5a;

   typedef enum logic [3:0] {
      ST_CMD = 4'b0001,
      ST_WR = 4'b0010,
      ST_RD = 4'b0100,
      ST_STREAM = 4'b1000
   } acp_state_t;

   // Length in bits of the register that a select code addresses.
   function automatic logic [4:0] reg_width(input logic [2:0] sel);
      case (sel)
         SEL_COMM, SEL_ID, SEL_IO: reg_width = 5'h08;
         SEL_MODE, SEL_CONF: reg_width = 5'h10;
         default: reg_width = 5'h18;
      endcase
   endfunction

endpackage

// File: core/acp_reg_bank.sv
// Register bank and conversion ready flag on the system clock.
// Assumes write, read and reset toggles from the serial clock domain.
`timescale 1ns/1ps
`default_nettype none
module acp_reg_bank (
   input wire logic clk_in,           // System clock.
   input wire logic rst_n_in,         // Asynchronous reset, active low.
   input wire logic ce_in,            // Clock enable.
   acp_bank_if.bank lk,               // Serial engine side.
   input wire logic conv_done_in,     // Conversion finished pulse.
   input wire logic [23:0] conv_data_in, // Finished conversion result.
   input wire logic update_near_in,   // Next update imminent pulse.
   output logic [15:0] mode_out,      // Mode register.
   output logic [15:0] config_out,    // Configuration register.
   output logic [7:0] io_out,         // IO register.
   output logic [23:0] offset_out,    // Offset register.
   output logic [23:0] fullscale_out, // Full-scale register.
   output logic part_reset_out        // Whole-part reset pulse.
);
   logic [2:0] tg_s1_reg;
   logic [2:0] tg_s2_reg;
   logic [2:0] tg_s3_reg;
   logic ready_reg;
   logic [23:0] data_reg;
   logic wr_pulse;
   logic rd_pulse;
   logic prst_pulse;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tg_s1_reg <= 3'h0;
         tg_s2_reg <= 3'h0;
         tg_s3_reg <= 3'h0;
      end else if (ce_in) begin
         tg_s1_reg <= {lk.prst_tgl, lk.rd_tgl, lk.wr_tgl};
         tg_s2_reg <= tg_s1_reg;
         tg_s3_reg <= tg_s2_reg;
      end
   end

   assign wr_pulse = ce_in && (tg_s2_reg[0] ^ tg_s3_reg[0]);
   assign rd_pulse = ce_in && (tg_s2_reg[1] ^ tg_s3_reg[1]);
   assign prst_pulse = ce_in && (tg_s2_reg[2] ^ tg_s3_reg[2]);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_out <= acp_pkg::MODE_RESET;
         config_out <= acp_pkg::CONF_RESET;
         io_out <= acp_pkg::IO_RESET;
         offset_out <= acp_pkg::OFFS_RESET;
         fullscale_out <= acp_pkg::FSCL_RESET;
      end else if (prst_pulse) begin
         mode_out <= acp_pkg::MODE_RESET;
         config_out <= acp_pkg::CONF_RESET;
         io_out <= acp_pkg::IO_RESET;
         offset_out <= acp_pkg::OFFS_RESET;
         fullscale_out <= acp_pkg::FSCL_RESET;
      end else if (wr_pulse) begin
         case (lk.wr_sel)
            acp_pkg::SEL_MODE: mode_out <= lk.wr_word[15:0];
            acp_pkg::SEL_CONF: config_out <= lk.wr_word[15:0];
            acp_pkg::SEL_IO: io_out <= lk.wr_word[7:0];
            acp_pkg::SEL_OFFS: offset_out <= lk.wr_word;
            acp_pkg::SEL_FSCL: fullscale_out <= lk.wr_word;
            default: io_out <= io_out;
         endcase
      end
   end

   // A new conversion beats a read completion or an update warning.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_reg <= 1'b0;
      end else if (prst_pulse) begin
         ready_reg <= 1'b0;
      end else if (ce_in && conv_done_in) begin
         ready_reg <= 1'b1;
      end else if (rd_pulse || (ce_in && update_near_in)) begin
         ready_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_reg <= acp_pkg::DATA_RESET;
         part_reset_out <= 1'b0;
      end else if (ce_in) begin
         part_reset_out <= prst_pulse;
         if (prst_pulse) begin
            data_reg <= acp_pkg::DATA_RESET;
         end else if (ce_in && conv_done_in) begin
            data_reg <= conv_data_in;
         end
      end
   end

   assign lk.ready = ready_reg;

   always_comb begin
      case (lk.rd_sel)
         acp_pkg::SEL_COMM: lk.rd_word = {16'h0000, !ready_reg, 7'h00};
         acp_pkg::SEL_MODE: lk.rd_word = {8'h00, mode_out};
         acp_pkg::SEL_CONF: lk.rd_word = {8'h00, config_out};
         acp_pkg::SEL_DATA: lk.rd_word = data_reg;
         acp_pkg::SEL_ID: lk.rd_word = {16'h0000, acp_pkg::ID_DEFAULT};
         acp_pkg::SEL_IO: lk.rd_word = {16'h0000, io_out};
         acp_pkg::SEL_OFFS: lk.rd_word = offset_out;
         default: lk.rd_word = fullscale_out;
      endcase
   end

   ready_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && conv_done_in && !prst_pulse |=> ready_reg)
      else $error("ready flag not set by a finished conversion");
   ready_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rd_pulse || (ce_in && update_near_in)) && !conv_done_in
      |=> !ready_reg)
      else $error("ready flag not cleared before the next update");
   ready_cause_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(ready_reg) |-> $past(conv_done_in))
      else $error("ready flag rose without a finished conversion");
   bank_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_pulse && !prst_pulse && lk.wr_sel == acp_pkg::SEL_MODE
      |=> mode_out == $past(lk.wr_word[15:0]))
      else $error("mode register did not take the shifted word");
   part_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      prst_pulse |=> !ready_reg && part_reset_out
      && mode_out == acp_pkg::MODE_RESET)
      else $error("whole-part reset did not restore the bank");
endmodule
`default_nettype wire

// File: verif/acp_host_model.sv
// Host side of the serial link: drives frames and captures the output pin.
// Assumes the design samples its input on rising serial clock edges.
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
   output logic sclk_out,          // Serial clock, idle high.
   output logic cs_n_out,          // Chip select, active low.
   output logic din_out,           // Serial data to the device.
   input wire logic dout_in,       // Serial data from the device.
   output logic [23:0] rx_out,     // Last bits captured in a frame.
   output logic rx_valid_out       // Pulse when rx_out is fresh.
);
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b0;
      rx_out = 24'h000000;
      rx_valid_out = 1'b0;
   end

   // The clock stands still between frames, so one frame is one call.
   task automatic xfer(input logic [39:0] tx, input int n, input bit note);
      logic [23:0] rx;
      rx = 24'h000000;
      cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #16 sclk_out = 1'b0;
         din_out = tx[i];
         #32 rx = {rx[22:0], dout_in};
         sclk_out = 1'b1;
         #16;
      end
      cs_n_out = 1'b1;
      din_out = ~din_out;
      // Chip select stays high for a while between two frames.
      #32;
      if (note) begin
         rx_out = rx;
         rx_valid_out = 1'b1;
         #10 rx_valid_out = 1'b0;
      end
   endtask

   // Clock edges with ones on the input while chip select is high.
   task automatic idle_clocks(input int n);
      din_out = 1'b1;
      repeat (n) begin
         #32 sclk_out = 1'b0;
         #32 sclk_out = 1'b1;
      end
      #16 din_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verif/adc_serial_command_port_tb.sv
// Self-checking bench for the serial command port.
// Assumes the package, interface, design and host model compile first.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_port_tb;
   logic clk_in, rst_n_in, conv_done_in, update_near_in;
   logic [23:0] conv_data_in, d, x, rx;
   logic sclk, cs_n, din, dout, dout_oe, rx_valid, prst;
   logic [15:0] mode;
   int prst_seen = 0;
   logic [47:0] exp_q[$];
   logic [47:0] e;
   int num_errors = 0;
   int checks = 0;
   int seed = 32'h57fc;
   logic [2:0] sels [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
   int widths [5] = '{16, 16, 8, 24, 24};

   acp_command_port u_acp_command_port (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n),
      .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
      .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
      .update_near_in(update_near_in), .mode_out(mode), .config_out(),
      .io_out(), .offset_out(), .fullscale_out(), .part_reset_out(prst));
   // A released pin shows the inverse of the port's dout_out value.
   acp_host_model u_acp_host_model (.sclk_out(sclk), .cs_n_out(cs_n),
      .din_out(din), .dout_in(dout_oe ? dout : !dout), .rx_out(rx),
      .rx_valid_out(rx_valid));

   always @(negedge clk_in) begin
      if (prst === 1'b1) prst_seen++;
   end

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic conclude();
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [23:0] ex, sn);
      checks++;
      if (sn !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, sn);
      end
   endtask

   task automatic pulse(input bit upd, input bit nd);
      @(posedge clk_in) #1;
      conv_done_in = !upd;
      update_near_in = upd;
      if (nd) conv_data_in = $random(seed);
      d = conv_data_in;
      @(posedge clk_in) #1;
      conv_done_in = 1'b0;
      update_near_in = 1'b0;
   endtask

   task automatic rd(input logic [2:0] sel, input int w, input logic [23:0] v);
      exp_q.push_back({24'((1 << w) - 1), v});
      u_acp_host_model.xfer(40'({2'b01, sel, 3'h0}) << w, 8 + w, 1'b1);
   endtask

   task automatic wr(input logic [2:0] sel, input int w, input logic [23:0] v);
      u_acp_host_model.xfer((40'({2'b00, sel, 3'h0}) << w) | 40'(v),
         8 + w, 1'b0);
   endtask

   always @(posedge rx_valid) begin
      e = exp_q.pop_front();
      checks++;
      if ((rx & e[47:24]) !== e[23:0]) begin
         num_errors++;
         $display("[ERR] rx_word expected %h seen %h", e[23:0], rx & e[47:24]);
      end
   end

   initial begin
      #500000;
      num_errors++;
      conclude();
   end

   initial begin
      rst_n_in = 1'b0;
      conv_done_in = 1'b0;
      update_near_in = 1'b0;
      conv_data_in = 24'h000000;
      repeat (10) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      exp_q.push_back({24'h0000ff, 24'h000080});
      u_acp_host_model.xfer(40'h74000, 19, 1'b1);
      for (int i = 0; i < 5; i++) begin
         x = $random(seed);
         x = x & 24'((1 << widths[i]) - 1);
         wr(sels[i], widths[i], x);
         rd(sels[i], widths[i], x);
      end
      rd(acp_pkg::SEL_ID, 8, 24'(acp_pkg::ID_DEFAULT));
      pulse(1'b0, 1'b1);
      rd(acp_pkg::SEL_COMM, 8, 24'h000000);
      rd(acp_pkg::SEL_DATA, 24, d);
      rd(acp_pkg::SEL_COMM, 8, 24'h000080);
      pulse(1'b0, 1'b1);
      pulse(1'b1, 1'b0);
      rd(acp_pkg::SEL_COMM, 8, 24'h000080);
      wr(acp_pkg::SEL_MODE, 16, 24'h001234);
      repeat (6) @(posedge clk_in);
      #1 chk("mode_out", 24'h001234, 24'(mode));
      u_acp_host_model.idle_clocks(40);
      rd(acp_pkg::SEL_MODE, 16, 24'h001234);
      u_acp_host_model.xfer(40'hffffffff, 32, 1'b0);
      repeat (6) @(posedge clk_in);
      #1 chk("mode_out", 24'h000000, 24'(mode));
      chk("part_reset_out", 24'h000001, 24'(prst_seen));
      rd(acp_pkg::SEL_MODE, 16, 24'h000000);
      pulse(1'b0, 1'b1);
      exp_q.push_back({24'hffffff, d});
      u_acp_host_model.xfer(40'h5c << 24, 32, 1'b1);
      pulse(1'b0, 1'b0);
      exp_q.push_back({24'hffffff, d});
      u_acp_host_model.xfer(40'h58, 24, 1'b1);
      rd(acp_pkg::SEL_ID, 8, 24'(acp_pkg::ID_DEFAULT));
      #1000;
      conclude();
   end
endmodule
`default_nettype wire
